// >>> hdl/gtc_top.sv
// Control register of a general timer counter with its 16-bit counter.
// Assumes single-cycle register strobes and one-cycle trigger pulses.
`timescale 1ns/100ps
`include "gtc_regs.svh"
module gtc_top
    import gtc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        reg_hword,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata_q,
    input  wire logic        car_wr,
    input  wire logic [15:0] car_wdata,
    input  wire logic        sw_update,
    input  wire logic        restart_trig,
    input  wire logic        encoder_mode,
    input  wire logic        encoder_dir,
    input  wire logic        chan_output_role,
    input  wire logic [15:0] chan_cmp_val,
    input  wire logic        chan_flag_clr,
    output logic      [15:0] count_q,
    output logic      [15:0] car_active_q,
    output logic             update_evt_q,
    output logic             update_req_q,
    output logic             reinit_q,
    output logic             channel_flag_q,
    output logic             sample_tick_q
);
    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] ctl_q;
    logic [31:0] ctl_d;
    gtc_phase_t  phase_q;
    gtc_phase_t  phase_d;
    gtc_cnt_t    cnt_d;
    gtc_cnt_t    car_d;
    gtc_cnt_t    pre_q;
    gtc_cnt_t    pre_d;
    logic [31:0] rdata_d;
    logic        upd_d;
    logic        req_d;
    logic        reinit_d;
    logic        flag_d;
    logic        wrap;
    logic        match;
    logic        acc_ok;
    logic        wr_lo;
    gtc_align_t  align;
    logic        center;
    logic        run;

    gtc_div_if div_ch ();

    gtc_div u_div
    (
        .clk  (clk),
        .nrst (nrst),
        .dv   (div_ch.div)
    );

    assign div_ch.code   = ctl_q[`GTC_DIV_LSB +: 2];
    assign sample_tick_q = div_ch.tick;

    assign align  = gtc_align_t'(ctl_q[`GTC_ALN_LSB +: 2]);
    assign center = (align != AL_EDGE);
    assign run    = ctl_q[`GTC_RUN_BIT];
    // Upper half is reserved: half-word access there reads zero, writes drop
    assign acc_ok = (reg_addr == `GTC_CTL0_OFS) || (reg_hword && reg_addr == `GTC_CTL0_HI);
    assign wr_lo  = reg_wr && (reg_addr == `GTC_CTL0_OFS);              // [R15]

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        ctl_d    = ctl_q;
        phase_d  = phase_q;
        cnt_d    = count_q;
        car_d    = car_active_q;
        pre_d    = pre_q;
        upd_d    = 1'b0;
        req_d    = 1'b0;
        reinit_d = 1'b0;
        wrap     = 1'b0;
        rdata_d  = 32'h0000_0000;
        if (reg_rd && reg_addr == `GTC_CTL0_OFS)
        begin
            rdata_d = ctl_q;
            rdata_d[`GTC_DIR_BIT] = phase_q;
        end
        if (wr_lo)
        begin
            ctl_d = reg_wdata & `GTC_CTL0_MASK;
            ctl_d[`GTC_DIR_BIT] = 1'b0;
            if (!center && !encoder_mode)
                phase_d = gtc_phase_t'(reg_wdata[`GTC_DIR_BIT]);  // [R8]
        end
        if (car_wr)
        begin
            pre_d = car_wdata;
            if (!ctl_q[`GTC_SHD_BIT])
                car_d = car_wdata;                                 // [R2]
        end
        if (encoder_mode && !center)
            phase_d = gtc_phase_t'(encoder_dir);                   // [R8]
        if (sw_update || restart_trig)
        begin
            // Reinit happens even with updates suppressed
            reinit_d = 1'b1;                                       // [R13]
            cnt_d = (!center && phase_q == PH_DOWN) ? car_active_q : 16'h0000;
            if (center)
                phase_d = PH_UP;
            if (!ctl_q[`GTC_SUPP_BIT])
            begin
                upd_d = 1'b1;                                      // [R12]
                req_d = !ctl_q[`GTC_ORIG_BIT];                     // [R10] [R11]
            end
        end
        else if (run)                                              // [R14]
        begin
            case (phase_q)
                PH_UP:
                begin
                    if (count_q >= car_active_q)
                    begin
                        wrap = 1'b1;                               // [R16]
                        if (center)
                        begin
                            cnt_d   = count_q - 16'h0001;          // [R4] [R5] [R6]
                            phase_d = PH_DOWN;
                        end
                        else
                            cnt_d = 16'h0000;                      // [R3]
                    end
                    else
                        cnt_d = count_q + 16'h0001;
                end
                PH_DOWN:
                begin
                    if (count_q == 16'h0000)
                    begin
                        wrap = 1'b1;                               // [R16]
                        if (center)
                        begin
                            cnt_d   = 16'h0001;
                            phase_d = PH_UP;
                        end
                        else
                            cnt_d = car_active_q;                  // [R3]
                    end
                    else
                        cnt_d = count_q - 16'h0001;
                end
                default: cnt_d = count_q;
            endcase
            if (wrap && !ctl_q[`GTC_SUPP_BIT])
            begin
                upd_d = 1'b1;                                      // [R12]
                req_d = 1'b1;                                      // [R10] [R11]
            end
            if (wrap && ctl_q[`GTC_ONES_BIT])
                ctl_d[`GTC_RUN_BIT] = 1'b0;                        // [R9]
        end
        if (upd_d)
            car_d = pre_d;                                         // [R2] [R12]
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        case (align)
            AL_DOWN: match = (phase_q == PH_DOWN);                 // [R4]
            AL_UP:   match = (phase_q == PH_UP);                   // [R5]
            default: match = 1'b1;                                 // [R6]
        endcase
        match  = match && run && chan_output_role && (count_q == chan_cmp_val);
        // Set beats a clear arriving in the same cycle
        flag_d = (channel_flag_q && !chan_flag_clr) || match;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctl_q          <= `GTC_CTL0_RST;                       // [R15]
            phase_q        <= PH_UP;
            count_q        <= 16'h0000;
            car_active_q   <= 16'h0000;
            pre_q          <= 16'h0000;
            reg_rdata_q    <= 32'h0000_0000;
            update_evt_q   <= 1'b0;
            update_req_q   <= 1'b0;
            reinit_q       <= 1'b0;
            channel_flag_q <= 1'b0;
        end
        else
        begin
            ctl_q          <= ctl_d;
            phase_q        <= phase_d;
            count_q        <= cnt_d;
            car_active_q   <= car_d;
            pre_q          <= pre_d;
            reg_rdata_q    <= acc_ok ? rdata_d : 32'h0000_0000;
            update_evt_q   <= upd_d;
            update_req_q   <= req_d;
            reinit_q       <= reinit_d;
            channel_flag_q <= flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_div_half_rate: assert property (sample_tick_q && $stable(ctl_q[`GTC_DIV_LSB +: 2]) // [R1]
        && ctl_q[`GTC_DIV_LSB +: 2] == `GTC_DIV_2 |=> !sample_tick_q)
        else $error("divide-by-2 tick too fast");
    a_shadow_hold: assert property (car_wr && ctl_q[`GTC_SHD_BIT] && !upd_d // [R2]
        |=> $stable(car_active_q)) else $error("shadowed reload changed early");
    a_direct_load: assert property (car_wr && !ctl_q[`GTC_SHD_BIT] // [R2]
        |=> car_active_q == $past(car_wdata)) else $error("direct reload lost");
    a_edge_wrap: assert property (run && !center && phase_q == PH_UP && !sw_update // [R3]
        && !restart_trig && count_q >= car_active_q |=> count_q == 16'h0000)
        else $error("up wrap not to zero");
    a_flag_phase: assert property ($rose(channel_flag_q) && align == AL_DOWN // [R4]
        |-> $past(phase_q) == PH_DOWN) else $error("flag set while counting up");
    // Only triggers and turns may move the phase while centre-aligned
    a_dir_locked: assert property (wr_lo && center && !sw_update && !restart_trig // [R8]
        && !wrap |=> $stable(phase_q)) else $error("direction written in centre mode");
    a_one_shot: assert property (run && wrap && ctl_q[`GTC_ONES_BIT] && !wr_lo // [R9]
        |=> !run) else $error("one-shot did not stop");
    a_origin_only: assert property (update_req_q && $past(ctl_q[`GTC_ORIG_BIT]) // [R11]
        |-> $past(wrap)) else $error("request from non-wrap source");
    a_suppress: assert property (ctl_q[`GTC_SUPP_BIT] |=> !update_evt_q) // [R13]
        else $error("update while suppressed");
    a_reinit: assert property (sw_update |=> reinit_q) else $error("no reinit"); // [R13]
    a_idle_hold: assert property (!run && !sw_update && !restart_trig // [R14]
        |=> $stable(count_q)) else $error("counter moved while stopped");

    c_center_turn: cover property (center && wrap && phase_q == PH_UP);
    c_sw_update:   cover property (sw_update && ctl_q[`GTC_SUPP_BIT]);
    c_one_shot:    cover property (run ##1 !run && ctl_q[`GTC_ONES_BIT]);
    c_flag_both:   cover property (align == AL_BOTH && match);
endmodule : gtc_top

// >>> inc/gtc_regs.svh
// Offsets, field positions and reset values of the timer control register.
// Assumes a byte-addressed register port with half-word and word accesses.
// How it works
// R1: Divider field picks sample clock of kernel clock /1, /2, /4; 11 reserved.
// R2: Shadow bit set: reload writes wait for update event; clear: immediate.
// R3: Alignment 00 counts edge-aligned in the direction bit's sense.
// R4: Alignment 01 centre-aligned; output-role compare flags only while counting down.
// R5: Alignment 10 centre-aligned; output-role compare flags only while counting up.
// R6: Alignment 11 centre-aligned; output-role compare flags in both phases.
// R7: Software never moves alignment from edge to centre while counter runs.
// R8: Direction 0 up, 1 down; read-only in centre or encoder operation.
// R9: One-shot bit stops the counter at the next update event; code stops it at the next wrap, even with updates suppressed.
// R10: Origin bit 0: trigger, wrap and restart all raise update request.
// R11: Origin bit 1: only counter wrap raises update request.
// R12: Suppress bit 0: updates happen and load shadow registers from preload.
// R13: Suppress bit 1: no update; trigger and restart still reinitialise counter.
// R14: Counter runs only while run bit is 1; software sets it itself.
// R15: Register takes half-word and word accesses; resets to all zeros.
// R16: Up wrap at reload value to zero; down wrap at zero to reload.
`ifndef GTC_REGS_SVH
`define GTC_REGS_SVH

`define GTC_CTL0_OFS   8'h00
`define GTC_CTL0_HI    8'h02
`define GTC_CTL0_RST   32'h0000_0000
`define GTC_CTL0_MASK  32'h0000_03ff

`define GTC_RUN_BIT    0
`define GTC_SUPP_BIT   1
`define GTC_ORIG_BIT   2
`define GTC_ONES_BIT   3
`define GTC_DIR_BIT    4
`define GTC_ALN_LSB    5
`define GTC_SHD_BIT    7
`define GTC_DIV_LSB    8

`define GTC_DIV_1      2'h0
`define GTC_DIV_2      2'h1
`define GTC_DIV_4      2'h2

`endif

// >>> inc/gtc_pkg.sv
// Types shared by the timer control block and its divider.
// Assumes gtc_regs.svh supplies the numeric constants.
package gtc_pkg;
    typedef logic [15:0] gtc_cnt_t;
    typedef enum logic [1:0] {AL_EDGE = 2'b00, AL_DOWN = 2'b01,
                              AL_UP = 2'b10, AL_BOTH = 2'b11} gtc_align_t;
    typedef enum logic {PH_UP = 1'b0, PH_DOWN = 1'b1} gtc_phase_t;
endpackage : gtc_pkg

// >>> inc/gtc_div_if.sv
// Carrier between the control register and the sample clock divider.
// Assumes both ends run on the same kernel clock.
`timescale 1ns/100ps
interface gtc_div_if;
    logic [1:0] code;
    logic       tick;
    modport ctl (output code, input tick);
    modport div (input code, output tick);
endinterface : gtc_div_if

// >>> hdl/gtc_div.sv
// Sample clock divider: one-cycle tick at kernel rate /1, /2 or /4.
// Assumes code comes from the control register in the same clock domain.
`timescale 1ns/100ps
`include "gtc_regs.svh"
module gtc_div
    import gtc_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    gtc_div_if.div    dv
);
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic       tick_q;
    logic       tick_d;

    always_comb
    begin
        cnt_d = cnt_q + 2'h1;
        case (dv.code)
            `GTC_DIV_1: tick_d = 1'b1;                   // [R1]
            `GTC_DIV_2: tick_d = cnt_q[0];               // [R1]
            `GTC_DIV_4: tick_d = (cnt_q == 2'h3);        // [R1]
            // Reserved code runs at full rate rather than stall filters
            default:    tick_d = 1'b1;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q  <= 2'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign dv.tick = tick_q;
endmodule : gtc_div

// >>> test/test_gtc_top.sv
// Self-checking bench for the timer control register and its counter.
// Assumes gtc_top plain ports and register constants from gtc_regs.svh.
`timescale 1ns/100ps
`include "gtc_regs.svh"
module test_gtc_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, reg_hword = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, v, d, rdata;
    logic        car_wr = 1'b0, sw_update = 1'b0, restart_trig = 1'b0;
    logic        encoder_mode = 1'b0, encoder_dir = 1'b0, chan_output_role = 1'b0;
    logic        chan_flag_clr = 1'b0;
    logic [15:0] car_wdata = 16'h0, chan_cmp_val = 16'h0, r, old_car;
    logic [31:0] reg_rdata_q;
    logic [15:0] count_q, car_active_q;
    logic        update_evt_q, update_req_q, reinit_q, channel_flag_q, sample_tick_q;
    int          fail_count = 0, samples_checked = 0, n;

    gtc_top u_gtc_top (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_hword(reg_hword), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .car_wr(car_wr), .car_wdata(car_wdata),
        .sw_update(sw_update), .restart_trig(restart_trig), .encoder_mode(encoder_mode),
        .encoder_dir(encoder_dir), .chan_output_role(chan_output_role),
        .chan_cmp_val(chan_cmp_val), .chan_flag_clr(chan_flag_clr), .count_q(count_q),
        .car_active_q(car_active_q), .update_evt_q(update_evt_q),
        .update_req_q(update_req_q), .reinit_q(reinit_q),
        .channel_flag_q(channel_flag_q), .sample_tick_q(sample_tick_q));

    always #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task test_done;
        begin
            if (fail_count == 0 && samples_checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask : test_done

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            samples_checked++;
            if (seen !== exp)
            begin
                fail_count++;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask : chk

    task tick;
        begin
            @(posedge clk);
            #1;
        end
    endtask : tick

    task wr(input logic [7:0] a, input logic [31:0] dv, input logic hw);
        begin
            tick();
            reg_wr = 1'b1;
            reg_addr = a;
            reg_wdata = dv;
            reg_hword = hw;
            tick();
            reg_wr = 1'b0;
        end
    endtask : wr

    task rd(input logic [7:0] a, input logic hw);
        begin
            tick();
            reg_rd = 1'b1;
            reg_addr = a;
            reg_hword = hw;
            tick();
            reg_rd = 1'b0;
            rdata = reg_rdata_q;
        end
    endtask : rd

    task cw(input logic [15:0] dv);
        begin
            tick();
            car_wr = 1'b1;
            car_wdata = dv;
            tick();
            car_wr = 1'b0;
        end
    endtask : cw

    task still;
        logic [15:0] s;
        begin
            s = count_q;
            repeat (4) tick();
            chk(count_q, s);
        end
    endtask : still

    // Trigger, then follow the counter cycle by cycle against a reference walk
    task walk(input logic [1:0] al, input logic dr, input logic [15:0] cmp, input logic org);
        logic [15:0] c;
        logic        dn, ev, fl, hit;
        begin
            chan_cmp_val = cmp;
            chan_flag_clr = 1'b1;
            sw_update = 1'b1;
            tick();
            sw_update = 1'b0;
            chan_flag_clr = 1'b0;
            chan_output_role = 1'b1;
            c = (al == 2'h0 && dr) ? r : 16'h0;
            dn = (al == 2'h0) ? dr : 1'b0;
            ev = 1'b1;
            fl = 1'b0;
            for (int i = 0; i < 3 * r + 6; i++)
            begin
                chk(count_q, c);
                chk(update_evt_q, ev);
                chk(update_req_q, ev && !(org && i == 0));
                chk(channel_flag_q, fl);
                hit = (c == cmp) && (al == 2'h0 || al == 2'h3 || (al == 2'h1) == dn);
                fl = fl | hit;
                ev = (dn && c == 16'h0) || (!dn && c >= r);
                if (al == 2'h0)
                    c = !dn ? (c >= r ? 16'h0 : c + 16'h1) : (c == 16'h0 ? r : c - 16'h1);
                else if (!dn)
                    {c, dn} = c >= r ? {r - 16'h1, 1'b1} : {c + 16'h1, 1'b0};
                else
                    {c, dn} = c == 16'h0 ? {16'h1, 1'b0} : {c - 16'h1, 1'b1};
                tick();
            end
            chan_output_role = 1'b0;
        end
    endtask : walk

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #(25 * 30000);
        fail_count++;
        test_done();
    end

    initial
    begin
        d = $urandom(32'hb936);
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'b1;
        rd(`GTC_CTL0_OFS, 1'b0);
        chk(rdata, `GTC_CTL0_RST);
        for (int i = 0; i < 6; i++)
        begin
            d = $urandom & 32'hffff_ff9e;
            wr(`GTC_CTL0_OFS, d, i[0]);
            rd(`GTC_CTL0_OFS, i[0]);
            chk(rdata, d & `GTC_CTL0_MASK);
        end
        wr(`GTC_CTL0_HI, 32'h0000_03ff, 1'b1);
        rd(`GTC_CTL0_OFS, 1'b0);
        chk(rdata, d & `GTC_CTL0_MASK);
        rd(8'h10, 1'b0);
        chk(rdata, 32'h0);
        for (int k = 0; k < 3; k++)
        begin
            wr(`GTC_CTL0_OFS, k << `GTC_DIV_LSB, 1'b0);
            n = 0;
            repeat (8)
            begin
                tick();
                n += sample_tick_q;
            end
            chk(n, 8 >> k);
        end
        for (int k = 0; k < 5; k++)
        begin
            r = 16'h3 + $urandom % 7;
            cw(r);
            chk(car_active_q, r);
            v = (k > 1 ? (k - 1) : 0) << `GTC_ALN_LSB | (k == 1) << `GTC_DIR_BIT;
            v = v | k[0] << `GTC_ORIG_BIT;
            wr(`GTC_CTL0_OFS, v, 1'b0);
            wr(`GTC_CTL0_OFS, v | 32'h1, 1'b0);
            walk(v[6:5], v[4], 16'h1 + $urandom % (r - 16'h1), v[2]);
            wr(`GTC_CTL0_OFS, v, 1'b0);
            still();
        end
        old_car = r;
        for (int m = 0; m < 8; m++)
        begin
            wr(`GTC_CTL0_OFS, 32'h80 | m[1:0] << `GTC_SUPP_BIT, 1'b0);
            r = $urandom;
            cw(r);
            chk(car_active_q, old_car);
            tick();
            sw_update = !m[2];
            restart_trig = m[2];
            tick();
            sw_update = 1'b0;
            restart_trig = 1'b0;
            chk(reinit_q, 1'b1);
            chk(update_evt_q, !m[0]);
            chk(update_req_q, !m[0] && !m[1]);
            tick();
            old_car = m[0] ? old_car : r;
            chk(car_active_q, old_car);
        end
        // Shadow off first, so the short reload takes effect at once
        wr(`GTC_CTL0_OFS, 32'h0, 1'b0);
        r = 16'h5;
        cw(r);
        wr(`GTC_CTL0_OFS, 32'h9, 1'b0);
        repeat (2 * r + 4) tick();
        rd(`GTC_CTL0_OFS, 1'b0);
        chk(rdata[0], 1'b0);
        chk(count_q, 16'h0);
        still();
        wr(`GTC_CTL0_OFS, 32'h20, 1'b0);
        wr(`GTC_CTL0_OFS, 32'h30, 1'b0);
        rd(`GTC_CTL0_OFS, 1'b0);
        chk(rdata, 32'h20);
        wr(`GTC_CTL0_OFS, 32'h0, 1'b0);
        encoder_mode = 1'b1;
        wr(`GTC_CTL0_OFS, 32'h10, 1'b0);
        rd(`GTC_CTL0_OFS, 1'b0);
        chk(rdata, 32'h0);
        encoder_dir = 1'b1;
        rd(`GTC_CTL0_OFS, 1'b0);
        chk(rdata, 32'h10);
        test_done();
    end
endmodule : test_gtc_top
